// File: design/bsiu_cfg.svh
/*
 * Constants of the bit and skip instruction unit: sizes, widths and reset values.
 * Assumes it is included by the package and the design modules by its bare name.
 */
// Operation
// RULE_01: Bit clear on IO drives the chosen bit to 0; other bits and flags kept.
// RULE_02: Bit set on IO drives the chosen bit to 1; other bits and flags kept.
// RULE_03: Bit toggle on IO inverts the chosen bit; other bits and flags kept.
// RULE_04: Bit clear on memory writes 0 to the chosen bit; rest and flags kept.
// RULE_05: Bit set on memory writes 1 to the chosen bit; rest and flags kept.
// RULE_06: Carry exchange swaps the chosen IO bit with the carry flag.
// RULE_07: For an output bit, carry exchange drives the old carry onto that bit.
// RULE_08: For an input bit, carry exchange captures the sampled pin into carry.
// RULE_09: Carry exchange changes only carry; zero, aux carry and overflow kept.
// RULE_10: Compare skip if equal suppresses the next instruction when operands match.
// RULE_11: Compare skip if unequal suppresses the next instruction when operands differ.
// RULE_12: Accumulator-first compares set all four flags as accumulator minus operand.
// RULE_13: Memory-first unequal compare sets all four flags as memory minus accumulator.
// RULE_14: Test skip low suppresses the next instruction on a 0 bit; flags kept.
// RULE_15: Test skip high suppresses the next instruction on a 1 bit; flags kept.
// RULE_16: Compare carry flags a borrow; zero flags equal operands.
// RULE_17: The bit index is a 3-bit field choosing bit 0 to 7 of a byte.
// RULE_18: A skipped instruction takes its slot as a no-operation with no effects.
`ifndef BSIU_CFG_SVH
`define BSIU_CFG_SVH

`define BSIU_NUM_PORTS 2
`define BSIU_PORT_AW 1
`define BSIU_MEM_AW 6
`define BSIU_MEM_DEPTH 64
`define BSIU_IO_RST 8'h00
`define BSIU_MEM_RST 8'h00
`define BSIU_FLAG_RST 1'b0
`define BSIU_BIT_IDX_W 3

`endif

// File: design/bsiu_pkg.sv
/*
 * Types of the bit and skip instruction unit.
 * Assumes bsiu_cfg.svh is on the include path.
 */
`include "bsiu_cfg.svh"

package bsiu_pkg;

    // ==========================================================
    // Operation codes
    typedef enum logic [3:0] {
        BSIU_NOP = 4'h0,
        BSIU_BIT_CLEAR_IO = 4'h1,
        BSIU_BIT_SET_IO = 4'h2,
        BSIU_TOGGLE_IO = 4'h3,
        BSIU_BIT_CLEAR_MEM = 4'h4,
        BSIU_BIT_SET_MEM = 4'h5,
        BSIU_CARRY_SWAP = 4'h6,
        BSIU_CEQ_A_IMM = 4'h7,
        BSIU_CEQ_A_MEM = 4'h8,
        BSIU_CEQ_MEM_A = 4'h9,
        BSIU_CNE_A_IMM = 4'ha,
        BSIU_CNE_A_MEM = 4'hb,
        BSIU_CNE_MEM_A = 4'hc,
        BSIU_TEST_SKIP_LOW = 4'hd,
        BSIU_TEST_SKIP_HIGH = 4'he
    } bsiu_op_e;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        BSIU_IDLE = 2'b00,
        BSIU_READ = 2'b01,
        BSIU_EXEC = 2'b10
    } bsiu_state_e;

    typedef logic [7:0] bsiu_byte_t;

endpackage : bsiu_pkg

// File: design/bsiu_mem.sv
/*
 * Data memory of the bit and skip instruction unit: one write port, one registered read.
 * Assumes one clock and a synchronous active-high reset; array contents clear with reset.
 */
`timescale 1ns/10ps
`include "bsiu_cfg.svh"

module bsiu_mem (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Write port
    input wire logic wr_en,
    input wire logic [`BSIU_MEM_AW-1:0] wr_addr,
    input wire bsiu_pkg::bsiu_byte_t wr_data,
    // Read port
    input wire logic [`BSIU_MEM_AW-1:0] rd_addr,
    output bsiu_pkg::bsiu_byte_t rd_data_q
);
    import bsiu_pkg::*;

    bsiu_byte_t mem_q [`BSIU_MEM_DEPTH];

    // Bytes clear with reset so a read-modify-write of a fresh byte never spreads unknowns.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < `BSIU_MEM_DEPTH; i++) begin
                mem_q[i] <= `BSIU_MEM_RST;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Read data comes a cycle after the address; a same-cycle write is not bypassed.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule : bsiu_mem

// File: design/bsiu_unit.sv
/*
 * Bit and skip instruction unit: executes single-bit IO and memory instructions,
 * carry exchange, compare-and-skip and IO bit test-and-skip.
 * Assumes the core presents one instruction per start pulse while idle, supplies the
 * accumulator value with it, and steers pin direction from its own direction registers.
 */
`timescale 1ns/10ps
`include "bsiu_cfg.svh"

module bsiu_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Instruction
    input wire logic start,
    input wire bsiu_pkg::bsiu_op_e op,
    input wire logic [`BSIU_PORT_AW-1:0] io_port,
    input wire logic [`BSIU_BIT_IDX_W-1:0] bit_idx,
    input wire logic [`BSIU_MEM_AW-1:0] mem_addr,
    input wire bsiu_pkg::bsiu_byte_t imm,
    input wire bsiu_pkg::bsiu_byte_t accumulator,
    // IO
    input wire logic [`BSIU_NUM_PORTS-1:0][7:0] io_dir,
    input wire logic [`BSIU_NUM_PORTS-1:0][7:0] io_pin,
    output logic [`BSIU_NUM_PORTS-1:0][7:0] io_out_q,
    // Status
    output logic busy_q,
    output logic done_q,
    output logic skip_q,
    output logic zero_flag_q,
    output logic carry_flag_q,
    output logic aux_carry_flag_q,
    output logic overflow_flag_q
);
    import bsiu_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic is_cmp(input bsiu_op_e o);
        is_cmp = (o >= BSIU_CEQ_A_IMM) && (o <= BSIU_CNE_MEM_A);
    endfunction : is_cmp

    function automatic logic is_mem_first(input bsiu_op_e o);
        is_mem_first = (o == BSIU_CEQ_MEM_A) || (o == BSIU_CNE_MEM_A);
    endfunction : is_mem_first

    function automatic logic is_imm(input bsiu_op_e o);
        is_imm = (o == BSIU_CEQ_A_IMM) || (o == BSIU_CNE_A_IMM);
    endfunction : is_imm

    bsiu_state_e state_q;
    bsiu_op_e op_q;
    logic [`BSIU_PORT_AW-1:0] port_q;
    logic [`BSIU_BIT_IDX_W-1:0] idx_q;
    logic [`BSIU_MEM_AW-1:0] addr_q;
    bsiu_byte_t imm_q;
    bsiu_byte_t accum_q;
    bsiu_byte_t mem_rdata;
    logic [`BSIU_NUM_PORTS-1:0][7:0] pin_meta_q;
    logic [`BSIU_NUM_PORTS-1:0][7:0] pin_sync_q;
    logic ex;
    logic take;
    logic io_rd_bit;
    logic mem_we;
    bsiu_byte_t mem_wdata;
    bsiu_byte_t a_op;
    bsiu_byte_t b_op;
    logic [8:0] diff;
    logic eq;

    assign ex = (state_q == BSIU_EXEC);
    assign take = start && (state_q == BSIU_IDLE);

    // ==========================================================
    // Pin synchronisers
    genvar gp;
    generate
        for (gp = 0; gp < `BSIU_NUM_PORTS; gp++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    pin_meta_q[gp] <= 8'h00;
                    pin_sync_q[gp] <= 8'h00;
                end else begin
                    pin_meta_q[gp] <= io_pin[gp];
                    pin_sync_q[gp] <= pin_meta_q[gp];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sequencer: take, memory read, execute.
    // Every instruction that is not skipped takes the same three cycles; a skipped one is done after one.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= BSIU_IDLE;
        end else begin
            unique case (state_q)
                BSIU_IDLE: begin
                    if (start && !skip_q) begin
                        state_q <= BSIU_READ;
                    end
                end
                BSIU_READ: begin
                    state_q <= BSIU_EXEC;
                end
                BSIU_EXEC: begin
                    state_q <= BSIU_IDLE;
                end
                default: begin
                    state_q <= BSIU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            op_q <= BSIU_NOP;
            port_q <= '0;
            idx_q <= '0;
            addr_q <= '0;
            imm_q <= 8'h00;
            accum_q <= 8'h00;
        end else if (take && !skip_q) begin
            op_q <= op;
            port_q <= io_port;
            idx_q <= bit_idx;
            addr_q <= mem_addr;
            imm_q <= imm;
            accum_q <= accumulator;
        end
    end

    // A skipped instruction is answered at once with done and has no other effect.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= (take && !skip_q) || (state_q == BSIU_READ);
            done_q <= ex || (take && skip_q); // RULE_18
        end
    end

    // ==========================================================
    // Operand selection and comparison
    // Reads the output latch for output bits and the synchronised pin for input bits.
    assign io_rd_bit = io_dir[port_q][idx_q] ? io_out_q[port_q][idx_q]
                                             : pin_sync_q[port_q][idx_q]; // RULE_17
    assign a_op = is_mem_first(op_q) ? mem_rdata : accum_q; // RULE_13
    assign b_op = is_mem_first(op_q) ? accum_q : (is_imm(op_q) ? imm_q : mem_rdata); // RULE_12
    assign diff = {1'b0, a_op} - {1'b0, b_op};
    assign eq = (a_op == b_op);

    // ==========================================================
    // Memory bit instructions
    assign mem_we = ex && ((op_q == BSIU_BIT_CLEAR_MEM) || (op_q == BSIU_BIT_SET_MEM));

    always_comb begin
        mem_wdata = mem_rdata;
        mem_wdata[idx_q] = (op_q == BSIU_BIT_SET_MEM); // RULE_04 RULE_05
    end

    bsiu_mem u_mem (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(mem_we),
        .wr_addr(addr_q),
        .wr_data(mem_wdata),
        .rd_addr(addr_q),
        .rd_data_q(mem_rdata)
    );

    // ==========================================================
    // IO output latches
    always_ff @(posedge core_clk) begin
        if (srst) begin
            io_out_q <= {`BSIU_NUM_PORTS{`BSIU_IO_RST}};
        end else if (ex) begin
            unique case (op_q)
                BSIU_BIT_CLEAR_IO: io_out_q[port_q][idx_q] <= 1'b0; // RULE_01
                BSIU_BIT_SET_IO: io_out_q[port_q][idx_q] <= 1'b1; // RULE_02
                BSIU_TOGGLE_IO: io_out_q[port_q][idx_q] <= ~io_out_q[port_q][idx_q]; // RULE_03
                BSIU_CARRY_SWAP: io_out_q[port_q][idx_q] <= carry_flag_q; // RULE_06 RULE_07
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Flags
    always_ff @(posedge core_clk) begin
        if (srst) begin
            zero_flag_q <= `BSIU_FLAG_RST;
            carry_flag_q <= `BSIU_FLAG_RST;
            aux_carry_flag_q <= `BSIU_FLAG_RST;
            overflow_flag_q <= `BSIU_FLAG_RST;
        end else if (ex && is_cmp(op_q)) begin
            zero_flag_q <= (diff[7:0] == 8'h00); // RULE_12 RULE_16
            carry_flag_q <= diff[8]; // RULE_16
            aux_carry_flag_q <= (a_op[3:0] < b_op[3:0]);
            overflow_flag_q <= (a_op[7] ^ b_op[7]) & (a_op[7] ^ diff[7]);
        end else if (ex && (op_q == BSIU_CARRY_SWAP)) begin
            carry_flag_q <= io_rd_bit; // RULE_06 RULE_08 RULE_09
        end
    end

    // ==========================================================
    // Skip of the following instruction
    always_ff @(posedge core_clk) begin
        if (srst) begin
            skip_q <= 1'b0;
        end else if (ex) begin
            unique case (op_q)
                BSIU_CEQ_A_IMM, BSIU_CEQ_A_MEM, BSIU_CEQ_MEM_A: skip_q <= eq; // RULE_10
                BSIU_CNE_A_IMM, BSIU_CNE_A_MEM, BSIU_CNE_MEM_A: skip_q <= !eq; // RULE_11
                BSIU_TEST_SKIP_LOW: skip_q <= !io_rd_bit; // RULE_14
                BSIU_TEST_SKIP_HIGH: skip_q <= io_rd_bit; // RULE_15
                default: skip_q <= 1'b0;
            endcase
        end else if (take) begin
            skip_q <= 1'b0; // RULE_18
        end
    end

    // ==========================================================
    // Checks
    sequence s_taken;
        start && (state_q == BSIU_IDLE) && !skip_q;
    endsequence
    sequence s_exec;
        (state_q == BSIU_READ) ##1 ex;
    endsequence

    property p_clear_io;
        @(posedge core_clk) disable iff (srst)
        ex && (op_q == BSIU_BIT_CLEAR_IO) |=> (io_out_q[port_q][idx_q] == 1'b0);
    endproperty
    a_clear_io: assert property (p_clear_io) else $error("io bit not cleared"); // RULE_01

    property p_set_io;
        @(posedge core_clk) disable iff (srst)
        ex && (op_q == BSIU_BIT_SET_IO) |=> (io_out_q[port_q][idx_q] == 1'b1);
    endproperty
    a_set_io: assert property (p_set_io) else $error("io bit not set"); // RULE_02

    property p_toggle_io;
        @(posedge core_clk) disable iff (srst)
        ex && (op_q == BSIU_TOGGLE_IO) |=> (io_out_q != $past(io_out_q))
            && (io_out_q[port_q][idx_q] != $past(io_out_q[port_q][idx_q]));
    endproperty
    a_toggle_io: assert property (p_toggle_io) else $error("io bit not toggled"); // RULE_03

    property p_mem_bit;
        @(posedge core_clk) disable iff (srst)
        mem_we |-> (mem_wdata[idx_q] == (op_q == BSIU_BIT_SET_MEM))
            && ((mem_wdata ^ mem_rdata) == ((mem_rdata ^ mem_wdata) & (8'h01 << idx_q)));
    endproperty
    a_mem_bit: assert property (p_mem_bit) else $error("memory bit write wrong"); // RULE_04

    property p_swap;
        @(posedge core_clk) disable iff (srst)
        ex && (op_q == BSIU_CARRY_SWAP) |=> (carry_flag_q == $past(io_rd_bit))
            && (io_out_q[port_q][idx_q] == $past(carry_flag_q)) && $stable(zero_flag_q);
    endproperty
    a_swap: assert property (p_swap) else $error("carry exchange wrong"); // RULE_06

    property p_flags_kept;
        @(posedge core_clk) disable iff (srst)
        ex && !is_cmp(op_q) |=> $stable({zero_flag_q, aux_carry_flag_q, overflow_flag_q});
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed"); // RULE_09

    property p_cmp_flags;
        @(posedge core_clk) disable iff (srst)
        ex && is_cmp(op_q) |=> (carry_flag_q == $past(b_op > a_op))
            && (zero_flag_q == $past(a_op == b_op));
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong"); // RULE_16

    property p_skip_eq;
        @(posedge core_clk) disable iff (srst)
        ex && is_cmp(op_q) |=> (skip_q == ($past(eq) ^ $past(op_q >= BSIU_CNE_A_IMM)));
    endproperty
    a_skip_eq: assert property (p_skip_eq) else $error("compare skip wrong"); // RULE_10

    property p_skipped_nop;
        @(posedge core_clk) disable iff (srst)
        start && (state_q == BSIU_IDLE) && skip_q |=> done_q && !skip_q && !busy_q
            && $stable(io_out_q) && $stable(carry_flag_q);
    endproperty
    a_skipped_nop: assert property (p_skipped_nop) else $error("skipped slot had effect"); // RULE_18

    property p_slot;
        @(posedge core_clk) disable iff (srst)
        s_taken |=> s_exec ##1 done_q;
    endproperty
    a_slot: assert property (p_slot) else $error("instruction slot length wrong"); // RULE_18

endmodule : bsiu_unit

// File: sim/bsiu_unit_tb.sv
/*
 * Self-checking testbench of the bit and skip instruction unit.
 * Assumes bsiu_pkg and bsiu_cfg.svh are compiled first; inputs change on the falling edge.
 */
`timescale 1ns/10ps
`include "bsiu_cfg.svh"

module bsiu_unit_tb;
    import bsiu_pkg::*;

    // ==========================================================
    // Signals and shadow state
    typedef struct {
        bsiu_op_e op;
        logic [0:0] port;
        logic [2:0] bidx;
        logic [5:0] addr;
        bsiu_byte_t imm;
        bsiu_byte_t accum;
        logic sk;
    } bsiu_row_s;

    logic core_clk, srst, start, busy_q, done_q, skip_q;
    logic zero_flag_q, carry_flag_q, aux_carry_flag_q, overflow_flag_q;
    bsiu_op_e op;
    logic [`BSIU_PORT_AW-1:0] io_port;
    logic [`BSIU_BIT_IDX_W-1:0] bit_idx;
    logic [`BSIU_MEM_AW-1:0] mem_addr;
    bsiu_byte_t imm, accumulator;
    logic [`BSIU_NUM_PORTS-1:0][7:0] io_dir, io_pin, io_out_q, exp_out;
    bsiu_byte_t mem_m [0:63];
    logic [3:0] exp_f;
    logic exp_sk;
    int n_fail, n_checks;

    // Port 0 drives its latch, port 1 reads its pins, so both swap cases are reached.
    bsiu_row_s rows [0:36] = '{
        '{BSIU_BIT_SET_IO, 1'b0, 3'h5, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_BIT_SET_IO, 1'b0, 3'h7, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_BIT_CLEAR_IO, 1'b0, 3'h5, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_TOGGLE_IO, 1'b0, 3'h3, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_BIT_SET_IO, 1'b1, 3'h2, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CEQ_A_IMM, 1'b0, 3'h0, 6'h00, 8'h42, 8'h38, 1'b0},
        '{BSIU_CARRY_SWAP, 1'b0, 3'h1, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CARRY_SWAP, 1'b0, 3'h1, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CARRY_SWAP, 1'b1, 3'h0, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CARRY_SWAP, 1'b1, 3'h1, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CEQ_A_IMM, 1'b0, 3'h0, 6'h00, 8'h38, 8'h38, 1'b1},
        '{BSIU_BIT_SET_IO, 1'b0, 3'h6, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CNE_A_IMM, 1'b0, 3'h0, 6'h00, 8'h6a, 8'h38, 1'b1},
        '{BSIU_TOGGLE_IO, 1'b0, 3'h7, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CNE_A_IMM, 1'b0, 3'h0, 6'h00, 8'h38, 8'h38, 1'b0},
        '{BSIU_CEQ_A_MEM, 1'b0, 3'h0, 6'h09, 8'h00, 8'h38, 1'b1},
        '{BSIU_CEQ_A_IMM, 1'b0, 3'h0, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CEQ_A_MEM, 1'b0, 3'h0, 6'h05, 8'h00, 8'h38, 1'b0},
        '{BSIU_CEQ_MEM_A, 1'b0, 3'h0, 6'h05, 8'h00, 8'h42, 1'b1},
        '{BSIU_BIT_CLEAR_IO, 1'b0, 3'h7, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CEQ_MEM_A, 1'b0, 3'h0, 6'h05, 8'h00, 8'h80, 1'b0},
        '{BSIU_CNE_A_MEM, 1'b0, 3'h0, 6'h09, 8'h00, 8'h42, 1'b1},
        '{BSIU_BIT_SET_MEM, 1'b0, 3'h0, 6'h09, 8'h00, 8'h00, 1'b0},
        '{BSIU_CNE_MEM_A, 1'b0, 3'h0, 6'h09, 8'h00, 8'h42, 1'b1},
        '{BSIU_TOGGLE_IO, 1'b1, 3'h3, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CNE_MEM_A, 1'b0, 3'h0, 6'h09, 8'h00, 8'h38, 1'b0},
        '{BSIU_TEST_SKIP_LOW, 1'b0, 3'h5, 6'h00, 8'h00, 8'h00, 1'b1},
        '{BSIU_BIT_SET_IO, 1'b0, 3'h4, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_TEST_SKIP_LOW, 1'b1, 3'h0, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_TEST_SKIP_HIGH, 1'b1, 3'h2, 6'h00, 8'h00, 8'h00, 1'b1},
        '{BSIU_NOP, 1'b0, 3'h0, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_TEST_SKIP_HIGH, 1'b0, 3'h5, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_BIT_CLEAR_MEM, 1'b0, 3'h3, 6'h09, 8'h00, 8'h00, 1'b0},
        '{BSIU_CEQ_A_MEM, 1'b0, 3'h0, 6'h09, 8'h00, 8'h30, 1'b1},
        '{BSIU_NOP, 1'b0, 3'h0, 6'h00, 8'h00, 8'h00, 1'b0},
        '{BSIU_CNE_A_IMM, 1'b0, 3'h0, 6'h00, 8'h01, 8'h80, 1'b1},
        '{BSIU_NOP, 1'b0, 3'h0, 6'h00, 8'h00, 8'h00, 1'b0}};

    bsiu_unit i_dut (.core_clk(core_clk), .srst(srst), .start(start), .op(op),
        .io_port(io_port), .bit_idx(bit_idx), .mem_addr(mem_addr), .imm(imm),
        .accumulator(accumulator), .io_dir(io_dir), .io_pin(io_pin), .io_out_q(io_out_q),
        .busy_q(busy_q), .done_q(done_q), .skip_q(skip_q), .zero_flag_q(zero_flag_q),
        .carry_flag_q(carry_flag_q), .aux_carry_flag_q(aux_carry_flag_q),
        .overflow_flag_q(overflow_flag_q));

    // ==========================================================
    // Helpers
    function automatic logic [3:0] subf(input bsiu_byte_t a, input bsiu_byte_t b);
        bsiu_byte_t r;
        r = a - b;
        return {a == b, a < b, a[3:0] < b[3:0], (a[7] ^ b[7]) & (a[7] ^ r[7])};
    endfunction : subf

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // Issues one instruction from a falling edge and checks it against the shadow model.
    task automatic exec(input bsiu_op_e o, input logic [0:0] p, input logic [2:0] b,
            input logic [5:0] ad, input bsiu_byte_t im, input bsiu_byte_t av, input logic sk);
        int n;
        logic bv, was;
        bsiu_byte_t m;
        was = exp_sk;
        bv = io_dir[p][b] ? exp_out[p][b] : io_pin[p][b];
        m = mem_m[ad];
        op = o;
        io_port = p;
        bit_idx = b;
        mem_addr = ad;
        imm = im;
        accumulator = av;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        n = 1;
        while (done_q !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        if (!was) begin
            case (o)
                BSIU_BIT_CLEAR_IO: exp_out[p][b] = 1'b0;
                BSIU_BIT_SET_IO: exp_out[p][b] = 1'b1;
                BSIU_TOGGLE_IO: exp_out[p][b] = ~exp_out[p][b];
                BSIU_BIT_CLEAR_MEM: mem_m[ad][b] = 1'b0;
                BSIU_BIT_SET_MEM: mem_m[ad][b] = 1'b1;
                BSIU_CARRY_SWAP: begin
                    exp_out[p][b] = exp_f[2];
                    exp_f[2] = bv;
                end
                BSIU_CEQ_A_IMM, BSIU_CNE_A_IMM: exp_f = subf(av, im);
                BSIU_CEQ_A_MEM, BSIU_CNE_A_MEM: exp_f = subf(av, m);
                BSIU_CEQ_MEM_A, BSIU_CNE_MEM_A: exp_f = subf(m, av);
                default: ;
            endcase
        end
        exp_sk = sk;
        chk("latency", n, was ? 24'h1 : 24'h3);
        chk("skip", skip_q, sk);
        chk("io_out", io_out_q, exp_out);
        chk("flags", {zero_flag_q, carry_flag_q, aux_carry_flag_q, overflow_flag_q}, exp_f);
    endtask : exec

    // ==========================================================
    // Clock, watchdog and sequence
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge core_clk);
        n_fail++;
        stop_test();
    end

    initial begin
        srst = 1'b1;
        start = 1'b0;
        op = BSIU_NOP;
        io_port = 1'h0;
        bit_idx = 3'h0;
        mem_addr = 6'h00;
        imm = 8'h00;
        accumulator = 8'h00;
        io_dir = 16'h00ff;
        io_pin = 16'ha500;
        exp_out = 16'h0000;
        exp_f = 4'h0;
        exp_sk = 1'b0;
        n_fail = 0;
        n_checks = 0;
        repeat (10) @(negedge core_clk);
        srst = 1'b0;
        chk("reset", {io_out_q, zero_flag_q, carry_flag_q, busy_q, done_q, skip_q}, 24'h0);
        // Memory is only reachable through the bit operations, so bytes are built bit by bit.
        for (int i = 0; i < 8; i++) begin
            exec(8'h42 >> i & 1 ? BSIU_BIT_SET_MEM : BSIU_BIT_CLEAR_MEM, 1'b0, 3'(i), 6'h05,
                8'h00, 8'h00, 1'b0);
            exec(8'h38 >> i & 1 ? BSIU_BIT_SET_MEM : BSIU_BIT_CLEAR_MEM, 1'b0, 3'(i), 6'h09,
                8'h00, 8'h00, 1'b0);
        end
        foreach (rows[i]) begin
            exec(rows[i].op, rows[i].port, rows[i].bidx, rows[i].addr, rows[i].imm,
                rows[i].accum, rows[i].sk);
        end
        // A start held into the busy cycle must not run a second time.
        op = BSIU_TOGGLE_IO;
        io_port = 1'h0;
        bit_idx = 3'h0;
        start = 1'b1;
        @(negedge core_clk);
        chk("busy", busy_q, 24'h1);
        @(negedge core_clk);
        chk("busy held", busy_q, 24'h1);
        start = 1'b0;
        repeat (4) @(negedge core_clk);
        exp_out[0][0] = ~exp_out[0][0];
        chk("refused start", io_out_q, exp_out);
        srst = 1'b1;
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        chk("mid reset", {io_out_q, zero_flag_q, carry_flag_q, busy_q, done_q, skip_q}, 24'h0);
        exp_out = 16'h0000;
        exp_f = 4'h0;
        exec(BSIU_BIT_SET_IO, 1'b1, 3'h7, 6'h00, 8'h00, 8'h00, 1'b0);
        stop_test();
    end

endmodule : bsiu_unit_tb
